// file: verilog/power_save_pkg.sv
package power_save_pkg;

  localparam logic [23:0] oscillator_config_addr = 24'hf80000;
  localparam logic [23:0] watchdog_config_addr = 24'hf80002;
  localparam logic [23:0] brownout_poweron_config_addr = 24'hf80004;
  localparam logic [23:0] code_segment_config_addr = 24'hf8000a;
  localparam logic [23:0] debug_config_addr = 24'hf8000c;
  localparam int config_word_count = 5;
  localparam int config_data_width = 16;
  localparam logic [15:0] config_word_reset = 16'hffff;
  localparam logic [2:0] config_index_none = 3'h7;
  localparam logic [2:0] priority_reset = 3'h0;

  typedef enum logic [1:0] {
    mode_run,
    mode_sleep,
    mode_idle
  } power_mode_t;

  // encoding of the power_save_instruction operand
  localparam logic save_kind_sleep = 1'b0;
  localparam logic save_kind_idle = 1'b1;

  typedef struct packed {
    logic power_on;
    logic brownout;
    logic master_clear;
  } reset_cause_t;

  typedef struct packed {
    logic valid;
    logic enabled;
    logic [2:0] level;
  } wake_irq_t;

  typedef struct packed {
    logic write;
    logic [2:0] index;
    logic [15:0] data;
  } program_port_t;

  typedef struct packed {
    logic sleep_status;
    logic idle_status;
    logic watchdog_timeout_flag;
  } reset_control_register_t;

  typedef struct packed {
    power_mode_t mode;
    reset_control_register_t status;
    logic resume;
    logic vector;
    logic [23:0] table_data;
    logic [config_word_count*config_data_width-1:0] config_words;
  } power_state_t;

endpackage

// file: verilog/sleep_idle_wake_control.sv
// Functional notes
// RQ1 - any reset kind brings the processor out of Sleep.
// RQ2 - non power-on reset sets sleep status; power-on reset clears it.
// RQ3 - watchdog expiry in Sleep wakes core, sets sleep and timeout flags.
// RQ4 - Idle gates the core clock; peripheral clock keeps running.
// RQ5 - oscillator stays enabled throughout Idle, unlike Sleep.
// RQ6 - per-peripheral idle bit decides whether that peripheral runs in Idle.
// RQ7 - fail-safe low power RC stays on in Idle when clock fail detect on.
// RQ8 - Idle ends on qualified interrupt, any reset, or watchdog expiry.
// RQ9 - leaving Idle re-applies core clock and resumes at next instruction.
// RQ10 - interrupt wake from Idle makes the core vector to its handler.
// RQ11 - interrupt wake from Idle sets the idle status flag.
// RQ12 - non power-on reset sets idle status; power-on reset clears it.
// RQ13 - watchdog expiry in Idle wakes core, sets idle and timeout flags.
// RQ14 - Idle wake inserts no start-up delay.
// RQ15 - configuration words are 24 bits, only low 16 bits hold data.
// RQ16 - five configuration words at fixed program-space addresses.
// RQ17 - software reads configuration words with table reads.
// RQ18 - interrupt wake from Sleep sets the sleep status flag.
// RQ19 - config words read-only to software; only programming path writes.
module sleep_idle_wake_control (
  input wire logic mclk,
  input wire logic nrst,
  input wire power_save_pkg::reset_cause_t reset_cause,
  input wire logic power_save_instruction,
  input wire logic power_save_kind,
  input wire power_save_pkg::wake_irq_t wake_irq,
  input wire logic [2:0] cpu_priority,
  input wire logic watchdog_enable,
  input wire logic watchdog_expired,
  input wire logic clock_fail_detect_enable,
  input wire logic [7:0] peripheral_idle_stop,
  input wire logic table_read,
  input wire logic [23:0] table_address,
  input wire power_save_pkg::program_port_t program_port,
  input wire logic status_clear,
  output logic core_clock_enable,
  output logic [7:0] peripheral_clock_enable,
  output logic oscillator_enable,
  output logic low_power_rc_oscillator,
  output logic resume_pulse,
  output logic vector_pulse,
  output power_save_pkg::reset_control_register_t reset_control_register,
  output logic [23:0] table_read_data
);
  import power_save_pkg::*;

  power_state_t state;
  power_state_t next_state;
  logic any_reset;
  logic irq_ok;
  logic [2:0] read_index;

  function automatic logic [2:0] config_index(input logic [23:0] addr);
    if (addr == oscillator_config_addr) begin
      config_index = 3'h0;
    end else if (addr == watchdog_config_addr) begin
      config_index = 3'h1;
    end else if (addr == brownout_poweron_config_addr) begin
      config_index = 3'h2;
    end else if (addr == code_segment_config_addr) begin
      config_index = 3'h3;
    end else if (addr == debug_config_addr) begin
      config_index = 3'h4;
    end else begin
      config_index = config_index_none;
    end
  endfunction

  // reset causes are pulses from the reset logic on this clock
  assign any_reset = reset_cause.power_on | reset_cause.brownout | reset_cause.master_clear;
  // an interrupt must be enabled and strictly above the running level
  assign irq_ok = wake_irq.valid & wake_irq.enabled & (wake_irq.level > cpu_priority);
  assign read_index = config_index(table_address); // [RQ16]

  always_comb begin
    next_state = state;
    next_state.resume = 1'b0;
    next_state.vector = 1'b0;
    if (status_clear) begin
      next_state.status = '0;
    end
    case (state.mode)
      mode_run: begin
        if (power_save_instruction) begin
          next_state.mode = (power_save_kind == save_kind_idle) ? mode_idle : mode_sleep;
        end
      end
      mode_sleep: begin
        if (irq_ok) begin
          next_state.mode = mode_run;
          next_state.resume = 1'b1;
          next_state.vector = 1'b1;
          next_state.status.sleep_status = 1'b1; // [RQ18]
        end else if (watchdog_enable && watchdog_expired) begin
          next_state.mode = mode_run;
          next_state.resume = 1'b1;
          next_state.status.sleep_status = 1'b1; // [RQ3]
          next_state.status.watchdog_timeout_flag = 1'b1; // [RQ3]
        end
      end
      mode_idle: begin
        // leave in the same edge: no oscillator or power timer wait here
        if (irq_ok) begin
          next_state.mode = mode_run; // [RQ8] [RQ14]
          next_state.resume = 1'b1; // [RQ9]
          next_state.vector = 1'b1; // [RQ10]
          next_state.status.idle_status = 1'b1; // [RQ11]
        end else if (watchdog_enable && watchdog_expired) begin
          next_state.mode = mode_run; // [RQ8]
          next_state.resume = 1'b1; // [RQ9]
          next_state.status.idle_status = 1'b1; // [RQ13]
          next_state.status.watchdog_timeout_flag = 1'b1; // [RQ13]
        end
      end
      default: begin
        next_state.mode = mode_run;
      end
    endcase
    // any reset wins over mode, pulse and status updates, including software clear; config writes and table reads still go ahead
    if (any_reset) begin
      next_state.mode = mode_run; // [RQ1] [RQ8]
      next_state.resume = 1'b0;
      next_state.vector = 1'b0;
      if (reset_cause.power_on) begin
        next_state.status = '0; // [RQ2] [RQ12]
      end else begin
        next_state.status.sleep_status = 1'b1; // [RQ2]
        next_state.status.idle_status = 1'b1; // [RQ12]
      end
    end
    // only the programming path can write; there is no software write port
    if (program_port.write && program_port.index < 3'(config_word_count)) begin
      next_state.config_words[program_port.index*config_data_width +: config_data_width] =
        program_port.data; // [RQ19]
    end
    if (table_read) begin
      if (read_index != config_index_none) begin
        // upper byte is unimplemented and reads zero
        next_state.table_data = {8'h00, // [RQ15]
          state.config_words[read_index*config_data_width +: config_data_width]}; // [RQ17]
      end else begin
        next_state.table_data = 24'h000000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state.mode <= mode_run;
      state.status <= '0;
      state.resume <= 1'b0;
      state.vector <= 1'b0;
      state.table_data <= 24'h000000;
      state.config_words <= {config_word_count{config_word_reset}};
    end else begin
      state <= next_state;
    end
  end

  assign core_clock_enable = (state.mode == mode_run); // [RQ4] [RQ9]
  assign oscillator_enable = (state.mode != mode_sleep); // [RQ5]
  assign low_power_rc_oscillator = clock_fail_detect_enable && (state.mode != mode_sleep); // [RQ7]

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_periph
      // peripherals run in Idle unless their own idle-stop bit is set
      assign peripheral_clock_enable[g] = (state.mode == mode_run) ||
        ((state.mode == mode_idle) && !peripheral_idle_stop[g]); // [RQ4] [RQ6]
    end
  endgenerate

  assign resume_pulse = state.resume;
  assign vector_pulse = state.vector;
  assign reset_control_register = state.status;
  assign table_read_data = state.table_data;

endmodule

// file: verification/watchdog_model.sv
module watchdog_model #(
  parameter int limit = 6
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic watchdog_enable,
  output logic watchdog_expired
);
  timeunit 1ns;
  timeprecision 1ps;
  int count;
  // nobody services it, so it keeps expiring once per wrap while enabled
  always_ff @(posedge mclk) begin
    if (!nrst || !watchdog_enable) count <= 0;
    else count <= (count == limit) ? 0 : count + 1;
  end
  assign watchdog_expired = watchdog_enable && count == limit;
endmodule

// file: verification/sleep_idle_wake_control_sva.sv
module sleep_idle_wake_control_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire power_save_pkg::reset_cause_t reset_cause,
  input wire logic power_save_instruction,
  input wire logic power_save_kind,
  input wire power_save_pkg::wake_irq_t wake_irq,
  input wire logic [2:0] cpu_priority,
  input wire logic watchdog_enable,
  input wire logic watchdog_expired,
  input wire logic [7:0] peripheral_idle_stop,
  input wire logic core_clock_enable,
  input wire logic [7:0] peripheral_clock_enable,
  input wire logic oscillator_enable,
  input wire logic resume_pulse,
  input wire logic vector_pulse,
  input wire power_save_pkg::reset_control_register_t reset_control_register
);
  import power_save_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic irq_ok = wake_irq.valid && wake_irq.enabled && wake_irq.level > cpu_priority;
  wire logic calm = reset_cause == 3'h0;
  wire logic idle = !core_clock_enable && oscillator_enable;
  // the interrupt outranks the watchdog, so only a lone expiry counts here
  wire logic dog = watchdog_enable && watchdog_expired && !irq_ok && calm;
  property p_idle_entry;
    power_save_instruction && power_save_kind == save_kind_idle && core_clock_enable && calm
      |=> !core_clock_enable && oscillator_enable;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");
  property p_periph; idle |-> peripheral_clock_enable == ~peripheral_idle_stop; endproperty
  a_periph: assert property (p_periph) else $error("idle peripheral gating wrong");
  property p_irq_wake;
    irq_ok && !core_clock_enable && calm |=> core_clock_enable && resume_pulse && vector_pulse;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq wake wrong");
  property p_dog_idle; dog && idle |=> resume_pulse && reset_control_register[1:0] == 2'b11;
  endproperty
  a_dog_idle: assert property (p_dog_idle) else $error("idle timeout wake wrong");
  property p_dog_sleep; dog && !oscillator_enable |=> core_clock_enable
    && reset_control_register[2] && reset_control_register[0]; endproperty
  a_dog_sleep: assert property (p_dog_sleep) else $error("sleep timeout wake wrong");
  property p_rst; !calm |=> core_clock_enable && !resume_pulse; endproperty
  a_rst: assert property (p_rst) else $error("reset did not wake");
  property p_por; reset_cause.power_on |=> reset_control_register == 3'h0; endproperty
  a_por: assert property (p_por) else $error("power-on flags wrong");
  property p_rst_flags;
    !calm && !reset_cause.power_on |=> reset_control_register[2:1] == 2'b11;
  endproperty
  a_rst_flags: assert property (p_rst_flags) else $error("reset flags wrong");
  c_irq: cover property (irq_ok && idle && calm);
  c_dog: cover property (dog && !oscillator_enable);
  c_rst: cover property (!calm && !core_clock_enable);
endmodule

bind sleep_idle_wake_control sleep_idle_wake_control_sva u_sleep_idle_wake_control_sva (
  .mclk, .nrst, .reset_cause, .power_save_instruction, .power_save_kind, .wake_irq,
  .cpu_priority, .watchdog_enable, .watchdog_expired, .peripheral_idle_stop,
  .core_clock_enable, .peripheral_clock_enable, .oscillator_enable, .resume_pulse,
  .vector_pulse, .reset_control_register);

// file: verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import power_save_pkg::*;
  logic mclk, nrst, power_save_instruction, power_save_kind, watchdog_enable, watchdog_expired;
  logic table_read, status_clear, clock_fail_detect_enable, core_clock_enable, vector_pulse;
  logic oscillator_enable, low_power_rc_oscillator, resume_pulse;
  logic [2:0] cpu_priority;
  logic [7:0] peripheral_idle_stop, peripheral_clock_enable;
  logic [23:0] table_address, table_read_data;
  reset_cause_t reset_cause;
  wake_irq_t wake_irq;
  program_port_t program_port;
  reset_control_register_t reset_control_register;
  logic [23:0] cfg [5] = '{oscillator_config_addr, watchdog_config_addr,
    brownout_poweron_config_addr, code_segment_config_addr, debug_config_addr};
  int fail_count = 0;
  int checked = 0;
  always #4 mclk = ~mclk;
  sleep_idle_wake_control u_sleep_idle_wake_control (.mclk, .nrst, .reset_cause,
    .power_save_instruction, .power_save_kind, .wake_irq, .cpu_priority, .watchdog_enable,
    .watchdog_expired, .clock_fail_detect_enable, .peripheral_idle_stop, .table_read,
    .table_address, .program_port, .status_clear, .core_clock_enable, .peripheral_clock_enable,
    .oscillator_enable, .low_power_rc_oscillator, .resume_pulse, .vector_pulse,
    .reset_control_register, .table_read_data);
  watchdog_model u_watchdog_model (.mclk, .nrst, .watchdog_enable, .watchdog_expired);
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rd(input logic [23:0] a, input logic [23:0] exp);
    table_address = a;
    table_read = 1'b1;
    @(negedge mclk);
    table_read = 1'b0;
    chk(table_read_data, exp);
  endtask
  task automatic enter(input logic kind);
    power_save_kind = kind;
    power_save_instruction = 1'b1;
    @(negedge mclk);
    power_save_instruction = 1'b0;
    status_clear = 1'b0;
  endtask
  initial begin
    #5000;
    fail_count++;
    $display("MISMATCH %0t run did not finish", $time);
    close_out();
  end
  initial begin
    {mclk, nrst, power_save_instruction, power_save_kind, watchdog_enable} = '0;
    {table_read, reset_cause, wake_irq, program_port, table_address} = '0;
    cpu_priority = 3'h2;
    peripheral_idle_stop = 8'h0f;
    clock_fail_detect_enable = 1'b1;
    status_clear = 1'b0;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    for (int i = 0; i < 5; i++) rd(cfg[i], {8'h00, config_word_reset});
    rd(24'hf80006, 24'h000000);
    program_port = '{1'b1, 3'h4, 16'ha5c3};
    @(negedge mclk);
    program_port = '0;
    rd(debug_config_addr, 24'h00a5c3);
    $display("test config words done");
    for (int k = 0; k < 2; k++) begin
      status_clear = 1'b1;
      enter(k[0]);
      chk({core_clock_enable, oscillator_enable, low_power_rc_oscillator, peripheral_clock_enable},
        {1'b0, k[0], k[0], k[0] ? 8'hf0 : 8'h00});
      wake_irq = '{1'b1, 1'b1, 3'h2};
      @(negedge mclk);
      chk(core_clock_enable, 1'b0);
      wake_irq.level = 3'h3;
      @(negedge mclk);
      wake_irq = '0;
      chk({core_clock_enable, resume_pulse, vector_pulse, reset_control_register},
        {3'b111, ~k[0], k[0], 1'b0});
      status_clear = 1'b1;
      watchdog_enable = 1'b1;
      enter(k[0]);
      for (int i = 0; i < 20 && resume_pulse !== 1'b1; i++) @(negedge mclk);
      watchdog_enable = 1'b0;
      chk({core_clock_enable, resume_pulse, vector_pulse, reset_control_register},
        {3'b110, ~k[0], k[0], 1'b1});
    end
    $display("test wake sources done");
    for (int i = 0; i < 3; i++) begin
      status_clear = 1'b1;
      enter(i[0]);
      reset_cause = 3'b001 << i;
      @(negedge mclk);
      reset_cause = '0;
      chk({core_clock_enable, resume_pulse, reset_control_register},
        {2'b10, i == 2 ? 3'b000 : 3'b110});
    end
    $display("test reset causes done");
    close_out();
  end
endmodule
